// File: rtl/rsdc_map.svh
`ifndef RSDC_MAP_SVH
`define RSDC_MAP_SVH

// Register offsets
`define RSDC_OFS_RX_CFG        8'h10
`define RSDC_OFS_SMP_LO        8'h11
`define RSDC_OFS_SMP_HI        8'h12
`define RSDC_OFS_STB_LO        8'h13
`define RSDC_OFS_STB_HI        8'h14
`define RSDC_OFS_SYNC_GAIN     8'h15
`define RSDC_OFS_SYNC_OUT      8'h16
`define RSDC_OFS_SYNC_WIN_LO   8'h17
`define RSDC_OFS_SYNC_WIN_HI   8'h18

// Reset values
`define RSDC_RST_RX_CFG        8'h42
`define RSDC_RST_SMP_LO        8'hDD
`define RSDC_RST_SMP_HI        8'h29
`define RSDC_RST_STB_LO        8'h71
`define RSDC_RST_STB_HI        8'h0A
`define RSDC_RST_SYNC_GAIN     8'h00
`define RSDC_RST_SYNC_OUT      8'h00
`define RSDC_RST_SYNC_WIN_LO   8'h00
`define RSDC_RST_SYNC_WIN_HI   8'h00

// Controller configuration bit positions
`define RSDC_BIT_RX_EN         0
`define RSDC_BIT_RX_LOOP       1
`define RSDC_BIT_RX_FLG_RST    2
`define RSDC_BIT_SYNC_EN       4
`define RSDC_BIT_SYNC_MST      5
`define RSDC_BIT_SYNC_LOOP     6
`define RSDC_BIT_SYNC_FLG_RST  7

// Bits that read back from the configuration register
`define RSDC_RX_CFG_RD_MASK    8'h73

// Largest search start value of a 10-bit delay line
`define RSDC_DELAY_MAX         10'h14C

`endif

// File: rtl/rsdc_pkg.sv
package rsdc_pkg;

    typedef logic [7:0] rsdc_byte_t;
    typedef logic [9:0] rsdc_dly_t;
    typedef logic [8:0] rsdc_win_t;
    typedef logic [6:0] rsdc_sync_dly_t;

    // Role of a delay setting: searched from by the controller, or applied as is
    typedef enum logic {
        RSDC_FIXED,
        RSDC_SEARCH
    } rsdc_mode_t;

endpackage : rsdc_pkg

// File: rtl/rsdc_sel_if.sv
`timescale 1ns/1ps

interface rsdc_sel_if #(
    parameter int W = 10
);
    logic [W-1:0] written;
    logic [W-1:0] live;
    logic         ctrl_en;
    logic [W-1:0] applied;
    logic [W-1:0] readback;

    modport bank (
        output written,
        output live,
        output ctrl_en,
        input  applied,
        input  readback
    );

    modport sel (
        input  written,
        input  live,
        input  ctrl_en,
        output applied,
        output readback
    );
endinterface : rsdc_sel_if

// File: rtl/rsdc_delay_sel.sv
`timescale 1ns/1ps

module rsdc_delay_sel #(
    parameter int W = 10,
    parameter logic [W-1:0] LIMIT = 10'h14C
) (
    rsdc_sel_if.sel port
);
    import rsdc_pkg::*;

    rsdc_mode_t mode;

    always_comb begin
        mode = port.ctrl_en ? RSDC_SEARCH : RSDC_FIXED;
        port.readback = port.written;
        // [RULE1] Clamped search start
        if (mode == RSDC_SEARCH && port.written > LIMIT) begin
            port.applied = LIMIT;
        end else begin
            // [RULE2] Fixed delay setting
            port.applied = port.written;
        end
    end
endmodule : rsdc_delay_sel

// File: rtl/rsdc_sync_rb.sv
`timescale 1ns/1ps

module rsdc_sync_rb #(
    parameter int W = 7
) (
    rsdc_sel_if.sel port
);
    import rsdc_pkg::*;

    // [RULE13] Setting or readback
    always_comb begin
        port.applied  = port.written;
        port.readback = port.ctrl_en ? port.live : port.written;
    end
endmodule : rsdc_sync_rb

// File: rtl/rsdc_bank.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "rsdc_map.svh"

// Notes on behaviour
// [RULE1] With receive controller on, sample code is the search start, capped at 332.
// [RULE2] With receive controller off, sample code is the fixed sampling delay.
// [RULE3] Strobe code is search start (capped 332) when on, fixed delay when off.
// [RULE4] Strobe code: four low bits high nibble, six high bits next register.
// [RULE5] Four-bit early/late window width, reset value one.
// [RULE6] Divider phase rotates 90 degrees per count, only with sync controller off.
// [RULE7] Two-bit sync tracking gain, reset zero.
// [RULE8] Sync output phase field reads the phase applied now.
// [RULE9] Four-bit lock threshold between sample and strobe delays, reset zero.
// [RULE10] Sync output delay is a setting when off, controller readback when on.
// [RULE11] Nine-bit sync window delay split over two registers, readback when on.
// [RULE12] Receive enable bit 0 selects search or fixed delay behaviour.
// [RULE13] Sync enable bit decides setting versus readback of sync delays.
module rsdc_bank (
    input  wire logic                     mclk_in,
    input  wire logic                     rst_in,
    input  wire logic [7:0]               addr_in,
    input  wire logic [7:0]               wr_data_in,
    input  wire logic                     wr_en_in,
    input  wire logic                     rd_en_in,
    output logic      [7:0]               rd_data_out,
    input  wire logic [1:0]               sync_out_phase_in,
    input  wire rsdc_pkg::rsdc_sync_dly_t sync_out_delay_live_in,
    input  wire rsdc_pkg::rsdc_win_t      sync_window_live_in,
    output logic                          rx_ctrl_enable_out,
    output logic                          rx_loop_on_out,
    output logic                          rx_flag_reset_out,
    output logic                          sync_ctrl_enable_out,
    output logic                          sync_master_out,
    output logic                          sync_loop_on_out,
    output logic                          sync_flag_reset_out,
    output rsdc_pkg::rsdc_dly_t           sample_delay_code_out,
    output rsdc_pkg::rsdc_dly_t           strobe_delay_code_out,
    output logic      [3:0]               pre_post_window_width_out,
    output logic      [1:0]               quarter_divider_phase_out,
    output logic      [1:0]               sync_track_gain_out,
    output logic      [3:0]               lock_delay_threshold_out,
    output rsdc_pkg::rsdc_sync_dly_t      sync_out_delay_code_out,
    output rsdc_pkg::rsdc_win_t           sync_sample_window_delay_out
);
    import rsdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    rsdc_byte_t rx_cfg_r,  rx_cfg_nxt;
    rsdc_byte_t smp_lo_r,  smp_lo_nxt;
    rsdc_byte_t smp_hi_r,  smp_hi_nxt;
    rsdc_byte_t stb_lo_r,  stb_lo_nxt;
    rsdc_byte_t stb_hi_r,  stb_hi_nxt;
    rsdc_byte_t gain_r,    gain_nxt;
    rsdc_byte_t sout_r,    sout_nxt;
    rsdc_byte_t win_lo_r,  win_lo_nxt;
    rsdc_byte_t win_hi_r,  win_hi_nxt;
    rsdc_byte_t rd_data_r, rd_data_nxt;

    logic rx_en;
    logic sync_en;

    always_comb begin
        rx_cfg_nxt = rx_cfg_r;
        smp_lo_nxt = smp_lo_r;
        smp_hi_nxt = smp_hi_r;
        stb_lo_nxt = stb_lo_r;
        stb_hi_nxt = stb_hi_r;
        gain_nxt   = gain_r;
        sout_nxt   = sout_r;
        win_lo_nxt = win_lo_r;
        win_hi_nxt = win_hi_r;
        if (wr_en_in) begin
            unique case (addr_in)
                `RSDC_OFS_RX_CFG:      rx_cfg_nxt = wr_data_in;
                `RSDC_OFS_SMP_LO:      smp_lo_nxt = wr_data_in;
                `RSDC_OFS_SMP_HI:      smp_hi_nxt = wr_data_in;
                `RSDC_OFS_STB_LO:      stb_lo_nxt = wr_data_in;
                `RSDC_OFS_STB_HI:      stb_hi_nxt = wr_data_in;
                `RSDC_OFS_SYNC_GAIN:   gain_nxt   = wr_data_in;
                // Bit 7 has no storage
                `RSDC_OFS_SYNC_OUT:    sout_nxt   = {1'b0, wr_data_in[6:0]};
                `RSDC_OFS_SYNC_WIN_LO: win_lo_nxt = wr_data_in;
                `RSDC_OFS_SYNC_WIN_HI: win_hi_nxt = wr_data_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rx_cfg_r <= `RSDC_RST_RX_CFG;
            smp_lo_r <= `RSDC_RST_SMP_LO;
            smp_hi_r <= `RSDC_RST_SMP_HI;
            stb_lo_r <= `RSDC_RST_STB_LO;
            stb_hi_r <= `RSDC_RST_STB_HI;
            gain_r   <= `RSDC_RST_SYNC_GAIN;
            sout_r   <= `RSDC_RST_SYNC_OUT;
            win_lo_r <= `RSDC_RST_SYNC_WIN_LO;
            win_hi_r <= `RSDC_RST_SYNC_WIN_HI;
        end else begin
            rx_cfg_r <= rx_cfg_nxt;
            smp_lo_r <= smp_lo_nxt;
            smp_hi_r <= smp_hi_nxt;
            stb_lo_r <= stb_lo_nxt;
            stb_hi_r <= stb_hi_nxt;
            gain_r   <= gain_nxt;
            sout_r   <= sout_nxt;
            win_lo_r <= win_lo_nxt;
            win_hi_r <= win_hi_nxt;
        end
    end

    // [RULE12] Receive enable select
    assign rx_en   = rx_cfg_r[`RSDC_BIT_RX_EN];
    // [RULE13] Sync enable select
    assign sync_en = rx_cfg_r[`RSDC_BIT_SYNC_EN];

    ////////////////////////////////////////////////////////////////////////////////
    // Delay selection

    rsdc_sel_if #(.W(10)) smp_if ();
    rsdc_sel_if #(.W(10)) stb_if ();
    rsdc_sel_if #(.W(7))  sout_if ();
    rsdc_sel_if #(.W(9))  win_if ();

    // [RULE1] Sample code assembly
    assign smp_if.written = {smp_hi_r, smp_lo_r[7:6]};
    assign smp_if.live    = '0;
    assign smp_if.ctrl_en = rx_en;

    // [RULE4] Strobe code assembly
    assign stb_if.written = {stb_hi_r[5:0], stb_lo_r[7:4]};
    assign stb_if.live    = '0;
    assign stb_if.ctrl_en = rx_en;

    // [RULE10] Sync output delay source
    assign sout_if.written = sout_r[6:0];
    assign sout_if.live    = sync_out_delay_live_in;
    assign sout_if.ctrl_en = sync_en;

    // [RULE11] Window delay assembly
    assign win_if.written = {win_hi_r, win_lo_r[7]};
    assign win_if.live    = sync_window_live_in;
    assign win_if.ctrl_en = sync_en;

    rsdc_delay_sel #(.W(10), .LIMIT(`RSDC_DELAY_MAX)) u_smp_sel (
        .port (smp_if.sel)
    );

    // [RULE3] Strobe start or fixed
    rsdc_delay_sel #(.W(10), .LIMIT(`RSDC_DELAY_MAX)) u_stb_sel (
        .port (stb_if.sel)
    );

    rsdc_sync_rb #(.W(7)) u_sout_rb (
        .port (sout_if.sel)
    );

    rsdc_sync_rb #(.W(9)) u_win_rb (
        .port (win_if.sel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: data valid only in the cycle after the strobe

    always_comb begin
        rd_data_nxt = 8'h00;
        if (rd_en_in) begin
            unique case (addr_in)
                // Flag reset bits are write only
                `RSDC_OFS_RX_CFG:      rd_data_nxt = rx_cfg_r & `RSDC_RX_CFG_RD_MASK;
                `RSDC_OFS_SMP_LO:      rd_data_nxt = smp_lo_r;
                `RSDC_OFS_SMP_HI:      rd_data_nxt = smp_hi_r;
                `RSDC_OFS_STB_LO:      rd_data_nxt = stb_lo_r;
                `RSDC_OFS_STB_HI:      rd_data_nxt = stb_hi_r;
                // [RULE8] Live phase readback
                `RSDC_OFS_SYNC_GAIN:   rd_data_nxt = {gain_r[7:6], sync_out_phase_in, gain_r[3:0]};
                // [RULE10] Delay readback
                `RSDC_OFS_SYNC_OUT:    rd_data_nxt = {1'b0, sout_if.readback};
                // [RULE11] Window readback
                `RSDC_OFS_SYNC_WIN_LO: rd_data_nxt = {win_if.readback[0], win_lo_r[6:0]};
                `RSDC_OFS_SYNC_WIN_HI: rd_data_nxt = win_if.readback[8:1];
                default:               rd_data_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data_out = rd_data_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Registered controls toward the controllers and delay lines

    // One flop per control, next value beside it
    logic           rx_ctrl_enable_r,    rx_ctrl_enable_nxt;
    logic           rx_loop_on_r,        rx_loop_on_nxt;
    logic           rx_flag_reset_r,     rx_flag_reset_nxt;
    logic           sync_ctrl_enable_r,  sync_ctrl_enable_nxt;
    logic           sync_master_r,       sync_master_nxt;
    logic           sync_loop_on_r,      sync_loop_on_nxt;
    logic           sync_flag_reset_r,   sync_flag_reset_nxt;
    rsdc_dly_t      sample_delay_r,      sample_delay_nxt;
    rsdc_dly_t      strobe_delay_r,      strobe_delay_nxt;
    logic [3:0]     window_width_r,      window_width_nxt;
    logic [1:0]     divider_phase_r,     divider_phase_nxt;
    logic [1:0]     track_gain_r,        track_gain_nxt;
    logic [3:0]     lock_threshold_r,    lock_threshold_nxt;
    rsdc_sync_dly_t sync_out_delay_r,    sync_out_delay_nxt;
    rsdc_win_t      sync_window_delay_r, sync_window_delay_nxt;

    always_comb begin
        // Enables and loop bits as written
        rx_ctrl_enable_nxt    = rx_en;
        rx_loop_on_nxt        = rx_cfg_r[`RSDC_BIT_RX_LOOP];
        // Level follows software: write 1 then 0 to clear flags
        rx_flag_reset_nxt     = rx_cfg_r[`RSDC_BIT_RX_FLG_RST];
        sync_ctrl_enable_nxt  = sync_en;
        sync_master_nxt       = rx_cfg_r[`RSDC_BIT_SYNC_MST];
        sync_loop_on_nxt      = rx_cfg_r[`RSDC_BIT_SYNC_LOOP];
        sync_flag_reset_nxt   = rx_cfg_r[`RSDC_BIT_SYNC_FLG_RST];
        // [RULE2] Applied sample delay
        sample_delay_nxt      = smp_if.applied;
        // [RULE3] Applied strobe delay
        strobe_delay_nxt      = stb_if.applied;
        // [RULE5] Window width
        window_width_nxt      = stb_lo_r[3:0];
        // [RULE6] Rotation only without sync; held at zero otherwise
        divider_phase_nxt     = sync_en ? 2'h0 : stb_hi_r[7:6];
        // [RULE7] Tracking gain
        track_gain_nxt        = gain_r[7:6];
        // [RULE9] Lock threshold
        lock_threshold_nxt    = gain_r[3:0];
        // [RULE10] Written delay to sync output
        sync_out_delay_nxt    = sout_if.applied;
        // [RULE11] Written window delay
        sync_window_delay_nxt = win_if.applied;
    end

    // Registered so the delay lines see one clean step per write
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            // Reset mirrors the register defaults
            rx_ctrl_enable_r    <= 1'b0;
            rx_loop_on_r        <= 1'b1;
            rx_flag_reset_r     <= 1'b0;
            sync_ctrl_enable_r  <= 1'b0;
            sync_master_r       <= 1'b0;
            sync_loop_on_r      <= 1'b1;
            sync_flag_reset_r   <= 1'b0;
            sample_delay_r      <= 10'h0A7;
            strobe_delay_r      <= 10'h0A7;
            window_width_r      <= 4'h1;
            divider_phase_r     <= 2'h0;
            track_gain_r        <= 2'h0;
            lock_threshold_r    <= 4'h0;
            sync_out_delay_r    <= 7'h00;
            sync_window_delay_r <= 9'h000;
        end else begin
            rx_ctrl_enable_r    <= rx_ctrl_enable_nxt;
            rx_loop_on_r        <= rx_loop_on_nxt;
            rx_flag_reset_r     <= rx_flag_reset_nxt;
            sync_ctrl_enable_r  <= sync_ctrl_enable_nxt;
            sync_master_r       <= sync_master_nxt;
            sync_loop_on_r      <= sync_loop_on_nxt;
            sync_flag_reset_r   <= sync_flag_reset_nxt;
            sample_delay_r      <= sample_delay_nxt;
            strobe_delay_r      <= strobe_delay_nxt;
            window_width_r      <= window_width_nxt;
            divider_phase_r     <= divider_phase_nxt;
            track_gain_r        <= track_gain_nxt;
            lock_threshold_r    <= lock_threshold_nxt;
            sync_out_delay_r    <= sync_out_delay_nxt;
            sync_window_delay_r <= sync_window_delay_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output ports straight from the flops above

    assign rx_ctrl_enable_out           = rx_ctrl_enable_r;
    assign rx_loop_on_out               = rx_loop_on_r;
    assign rx_flag_reset_out            = rx_flag_reset_r;
    assign sync_ctrl_enable_out         = sync_ctrl_enable_r;
    assign sync_master_out              = sync_master_r;
    assign sync_loop_on_out             = sync_loop_on_r;
    assign sync_flag_reset_out          = sync_flag_reset_r;
    assign sample_delay_code_out        = sample_delay_r;
    assign strobe_delay_code_out        = strobe_delay_r;
    assign pre_post_window_width_out    = window_width_r;
    assign quarter_divider_phase_out    = divider_phase_r;
    assign sync_track_gain_out          = track_gain_r;
    assign lock_delay_threshold_out     = lock_threshold_r;
    assign sync_out_delay_code_out      = sync_out_delay_r;
    assign sync_sample_window_delay_out = sync_window_delay_r;

endmodule : rsdc_bank

// File: tb/rsdc_bank_properties.sv
`timescale 1ns/1ps
`include "rsdc_map.svh"

module rsdc_bank_properties (
    input wire logic                     mclk_in,
    input wire logic                     rst_in,
    input wire logic [7:0]               addr_in,
    input wire logic [7:0]               wr_data_in,
    input wire logic                     wr_en_in,
    input wire logic                     rd_en_in,
    input wire logic [7:0]               rd_data_out,
    input wire logic [1:0]               sync_out_phase_in,
    input wire rsdc_pkg::rsdc_sync_dly_t sync_out_delay_live_in,
    input wire logic                     rx_ctrl_enable_out,
    input wire logic                     sync_ctrl_enable_out,
    input wire rsdc_pkg::rsdc_dly_t      sample_delay_code_out,
    input wire rsdc_pkg::rsdc_dly_t      strobe_delay_code_out,
    input wire logic [1:0]               quarter_divider_phase_out,
    input wire logic [1:0]               sync_track_gain_out,
    input wire logic [3:0]               lock_delay_threshold_out
);
    import rsdc_pkg::*;

    // Write data two edges back, when the outputs show it
    logic [7:0] wd1_r;
    logic [7:0] wd2_r;
    always_ff @(posedge mclk_in) begin
        wd1_r <= wr_data_in;
        wd2_r <= wd1_r;
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    ////////////////////////////////////////////////////////////////////////////
    smp_clamp_a: assert property (rx_ctrl_enable_out |-> sample_delay_code_out <= 10'h14C)
        else $error("sample code above limit while searching");
    smp_fixed_a: assert property (wr_en_in && addr_in == 8'h12 |-> ##2
        (rx_ctrl_enable_out || sample_delay_code_out[9:2] == wd2_r))
        else $error("fixed sample code not applied");
    stb_clamp_a: assert property (rx_ctrl_enable_out |-> strobe_delay_code_out <= 10'h14C)
        else $error("strobe code above limit while searching");
    stb_high_a: assert property (wr_en_in && addr_in == 8'h14 |-> ##2
        (rx_ctrl_enable_out || strobe_delay_code_out[9:4] == wd2_r[5:0]))
        else $error("strobe code high bits misplaced");
    div_phase_a: assert property (sync_ctrl_enable_out |-> quarter_divider_phase_out == 2'h0)
        else $error("divider phase applied with sync on");
    gain_thr_a: assert property (wr_en_in && addr_in == 8'h15 |-> ##2
        {sync_track_gain_out, lock_delay_threshold_out} == {wd2_r[7:6], wd2_r[3:0]})
        else $error("gain or threshold not applied");
    phase_live_a: assert property (rd_en_in && addr_in == 8'h15 |=>
        rd_data_out[5:4] == $past(sync_out_phase_in))
        else $error("phase readback not live");
    sync_dly_rb_a: assert property (rd_en_in && addr_in == 8'h16 && sync_ctrl_enable_out
        && !$past(wr_en_in) |=> rd_data_out == {1'b0, $past(sync_out_delay_live_in)})
        else $error("sync delay readback wrong");
endmodule : rsdc_bank_properties

bind rsdc_bank rsdc_bank_properties chk_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .sync_out_phase_in(sync_out_phase_in), .sync_out_delay_live_in(sync_out_delay_live_in),
    .rx_ctrl_enable_out(rx_ctrl_enable_out), .sync_ctrl_enable_out(sync_ctrl_enable_out),
    .sample_delay_code_out(sample_delay_code_out), .strobe_delay_code_out(strobe_delay_code_out),
    .quarter_divider_phase_out(quarter_divider_phase_out), .sync_track_gain_out(sync_track_gain_out),
    .lock_delay_threshold_out(lock_delay_threshold_out)
);

// File: tb/rsdc_bank_tb.sv
`timescale 1ns/1ps

module rsdc_bank_tb;
    import rsdc_pkg::*;

    logic           mclk_in, rst_in, wr_en_in, rd_en_in;
    logic [7:0]     addr_in, wr_data_in, rd_data_out;
    logic [1:0]     ph, dph, gain;
    logic [3:0]     win, thr;
    logic           rx_en, rx_loop, rx_flg, sy_en, sy_mst, sy_loop, sy_flg;
    rsdc_dly_t      smp, stb;
    rsdc_sync_dly_t so_live, so_dly;
    rsdc_win_t      sh_live, sh_dly;
    int             bad_count, total_checks, cyc;
    logic [7:0]     rst_tbl [9] = '{8'h42, 8'hDD, 8'h29, 8'h71, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h00};

    rsdc_bank dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .sync_out_phase_in(ph), .sync_out_delay_live_in(so_live), .sync_window_live_in(sh_live),
        .rx_ctrl_enable_out(rx_en), .rx_loop_on_out(rx_loop), .rx_flag_reset_out(rx_flg),
        .sync_ctrl_enable_out(sy_en), .sync_master_out(sy_mst), .sync_loop_on_out(sy_loop),
        .sync_flag_reset_out(sy_flg), .sample_delay_code_out(smp), .strobe_delay_code_out(stb),
        .pre_post_window_width_out(win), .quarter_divider_phase_out(dph), .sync_track_gain_out(gain),
        .lock_delay_threshold_out(thr), .sync_out_delay_code_out(so_dly), .sync_sample_window_delay_out(sh_dly)
    );

    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_en_in   <= 1'b1;
        @(posedge mclk_in);
        wr_en_in   <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        addr_in  <= a;
        rd_en_in <= 1'b1;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {2'b00, e}, {2'b00, rd_data_out});
    endtask : rd

    // Outputs lag the register by one edge
    task automatic settle;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask : settle

    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_in, wr_en_in, rd_en_in, addr_in, wr_data_in, ph, so_live, sh_live} = {1'b1, 36'h0};
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        chk("sample code", 10'h0A7, smp);
        chk("strobe code", 10'h0A7, stb);
        chk("window", 10'h001, {6'h00, win});
        chk("gain thr", 10'h000, {4'h0, gain, thr});
        chk("config bits", 10'h022, {3'h0, sy_flg, sy_loop, sy_mst, sy_en, rx_flg, rx_loop, rx_en});
        chk("divider phase", 10'h000, {8'h00, dph});
        chk("sync out delay", 10'h000, {3'h0, so_dly});
        chk("sync window", 10'h000, {1'b0, sh_dly});
        for (int i = 0; i < 9; i++) rd(8'h10 + 8'(i), rst_tbl[i]);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        rd(8'h0F, 8'h00);
        wr(8'h11, 8'hC0);
        wr(8'h12, 8'hFF);
        settle;
        chk("sample code", 10'h3FF, smp);
        wr(8'h10, 8'h43);
        settle;
        chk("sample code", 10'h14C, smp);
        rd(8'h12, 8'hFF);
        // Read data must drop back to zero one cycle later
        @(posedge mclk_in);
        #1;
        chk("read idle", 10'h000, {2'b00, rd_data_out});
        wr(8'h11, 8'h40);
        wr(8'h12, 8'h53);
        settle;
        chk("sample code", 10'h14C, smp);
        wr(8'h12, 8'h52);
        settle;
        chk("sample code", 10'h149, smp);
        wr(8'h13, 8'hC5);
        wr(8'h14, 8'h14);
        settle;
        chk("strobe code", 10'h14C, stb);
        chk("window", 10'h005, {6'h00, win});
        wr(8'h14, 8'h3F);
        settle;
        chk("strobe code", 10'h14C, stb);
        wr(8'h10, 8'h42);
        wr(8'h14, 8'hFF);
        settle;
        chk("strobe code", 10'h3FC, stb);
        chk("sample code", 10'h149, smp);
        chk("divider phase", 10'h003, {8'h00, dph});
        ph <= 2'b10;
        wr(8'h15, 8'h42);
        settle;
        chk("gain thr", 10'h012, {4'h0, gain, thr});
        rd(8'h15, 8'h62);
        wr(8'h16, 8'hFF);
        wr(8'h17, 8'h80);
        wr(8'h18, 8'hA5);
        settle;
        chk("sync out delay", 10'h07F, {3'h0, so_dly});
        chk("sync window", 10'h14B, {1'b0, sh_dly});
        rd(8'h16, 8'h7F);
        rd(8'h17, 8'h80);
        rd(8'h18, 8'hA5);
        so_live <= 7'h55;
        sh_live <= 9'h1C2;
        wr(8'h10, 8'h52);
        settle;
        chk("divider phase", 10'h000, {8'h00, dph});
        rd(8'h16, 8'h55);
        rd(8'h17, 8'h00);
        rd(8'h18, 8'hE1);
        chk("sync out delay", 10'h07F, {3'h0, so_dly});
        wr(8'h10, 8'hFF);
        settle;
        chk("config bits", 10'h07F, {3'h0, sy_flg, sy_loop, sy_mst, sy_en, rx_flg, rx_loop, rx_en});
        rd(8'h10, 8'h73);
        end_sim;
    end
endmodule : rsdc_bank_tb
